/* File: src/hte_irq_top.sv */
// event and interrupt sources of an hdmi transmitter
// assumes clear strobes come from logic on SYS_CLK; all other inputs are asynchronous
`include "hte_params.svh"

module hte_irq_top
   import hte_pkg::*;
#(
   parameter bit HDCP14_EN = 1'b1,
   parameter bit HDCP22_EN = 1'b1
)
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_B,
   // regenerated link clock
   input wire logic LINK_CLK,
   // asynchronous event inputs
   input wire logic HPD_IN,
   input wire logic VSYNC_IN,
   input wire logic HDCP14_IRQ_IN,
   input wire logic HDCP14_TMR_IN,
   input wire logic HDCP22_TMR_IN,
   // pending flag clear strobes, one per event
   input wire logic [`HTE_EV_NUM-1:0] EV_CLR,
   // pending flags and levels
   output logic [`HTE_EV_NUM-1:0] EV_PENDING,
   output logic HPD_LEVEL,
   output logic LINK_STATUS,
   // interrupt lines toward the processor
   output logic IRQ_HPD,
   output logic IRQ_LINK,
   output logic IRQ_VSYNC,
   output logic IRQ_HDCP14,
   output logic IRQ_HDCP14_TMR,
   output logic IRQ_HDCP22_TMR
);

   // ---------------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------------
   logic [`HTE_IN_NUM-1:0] pin_raw;
   logic [`HTE_IN_NUM-1:0] in_s1_q;
   logic [`HTE_IN_NUM-1:0] in_s2_q;
   logic [`HTE_IN_NUM-1:0] in_p_q;
   logic [`HTE_IN_NUM-1:0] in_rise;
   logic [`HTE_IN_NUM-1:0] in_fall;
   logic [`HTE_IN_NUM-1:0] in_keep;

   assign pin_raw[`HTE_IN_HPD] = HPD_IN;
   assign pin_raw[`HTE_IN_VS] = VSYNC_IN;
   assign pin_raw[`HTE_IN_H14] = HDCP14_IRQ_IN;
   assign pin_raw[`HTE_IN_H14T] = HDCP14_TMR_IN;
   assign pin_raw[`HTE_IN_H22T] = HDCP22_TMR_IN;

   // [RQ9] [RQ10] build gating
   // hdcp inputs of an absent engine are ignored entirely
   assign in_keep[`HTE_IN_HPD] = 1'b1;
   assign in_keep[`HTE_IN_VS] = 1'b1;
   assign in_keep[`HTE_IN_H14] = HDCP14_EN;
   assign in_keep[`HTE_IN_H14T] = HDCP14_EN;
   assign in_keep[`HTE_IN_H22T] = HDCP22_EN;

   // two flops per pin, a third remembers the last settled level
   genvar gi;
   generate
      for (gi = 0; gi < `HTE_IN_NUM; gi++)
      begin : g_sync
         always_ff @(posedge SYS_CLK or negedge RST_B)
            if (!RST_B)
            begin
               in_s1_q[gi] <= 1'b0;
               in_s2_q[gi] <= 1'b0;
               in_p_q[gi] <= 1'b0;
            end
            else
            begin
               in_s1_q[gi] <= pin_raw[gi];
               in_s2_q[gi] <= in_s1_q[gi];
               in_p_q[gi] <= in_s2_q[gi];
            end
         assign in_rise[gi] = in_keep[gi] & in_s2_q[gi] & ~in_p_q[gi];
         assign in_fall[gi] = in_keep[gi] & ~in_s2_q[gi] & in_p_q[gi];
      end
   endgenerate

   // ---------------------------------------------------------------------
   // link clock status
   // ---------------------------------------------------------------------
   logic link_s;
   logic link_p_q;

   // monitor crosses the link clock itself; its output is already on SYS_CLK
   hte_link_mon u_link_mon (
      .sys_clk(SYS_CLK),
      .rst_b(RST_B),
      .link_clk(LINK_CLK),
      .link_up(link_s)
   );

   // previous status, for transition detection
   always_ff @(posedge SYS_CLK or negedge RST_B)
      if (!RST_B)
         link_p_q <= 1'b0;
      else
         link_p_q <= link_s;

   // ---------------------------------------------------------------------
   // event decode
   // ---------------------------------------------------------------------
   hte_ev_t ev;

   always_comb
   begin
      ev = '0;
      // [RQ1] cable connected
      ev[`HTE_EV_CONN] = in_rise[`HTE_IN_HPD];
      // [RQ2] cable disconnected
      ev[`HTE_EV_DISC] = in_fall[`HTE_IN_HPD];
      // [RQ5] any link status change
      ev[`HTE_EV_LINK] = link_s ^ link_p_q;
      // [RQ6] stream up
      ev[`HTE_EV_UP] = link_s & ~link_p_q;
      // [RQ7] stream down
      ev[`HTE_EV_DOWN] = ~link_s & link_p_q;
      // [RQ8] vertical sync start
      ev[`HTE_EV_VS] = in_rise[`HTE_IN_VS];
      // [RQ9] hdcp 1.4 sources, gated by build
      ev[`HTE_EV_H14] = in_rise[`HTE_IN_H14];
      ev[`HTE_EV_H14T] = in_rise[`HTE_IN_H14T];
      // [RQ10] hdcp 2.2 timer, gated by build
      ev[`HTE_EV_H22T] = in_rise[`HTE_IN_H22T];
   end

   // ---------------------------------------------------------------------
   // pending flags
   // ---------------------------------------------------------------------
   hte_ev_t pend_d;

   // [RQ11] sticky flags, new event beats a clear in the same cycle
   always_comb
   begin
      pend_d = ev | (EV_PENDING & ~EV_CLR);
   end

   always_ff @(posedge SYS_CLK or negedge RST_B)
      if (!RST_B)
         EV_PENDING <= `HTE_PEND_RST;
      else
         EV_PENDING <= pend_d;

   // ---------------------------------------------------------------------
   // levels shown beside the flags
   // ---------------------------------------------------------------------
   // levels let software tell connect from disconnect when both are pending
   always_ff @(posedge SYS_CLK or negedge RST_B)
      if (!RST_B)
      begin
         HPD_LEVEL <= 1'b0;
         LINK_STATUS <= 1'b0;
      end
      else
      begin
         HPD_LEVEL <= in_s2_q[`HTE_IN_HPD];
         // [RQ3] [RQ4] status bit out
         LINK_STATUS <= link_s;
      end

   // ---------------------------------------------------------------------
   // interrupt lines
   // ---------------------------------------------------------------------
   // registered from the flags, so lines lag the flags by one cycle
   always_ff @(posedge SYS_CLK or negedge RST_B)
      if (!RST_B)
      begin
         IRQ_HPD <= 1'b0;
         IRQ_LINK <= 1'b0;
         IRQ_VSYNC <= 1'b0;
         IRQ_HDCP14 <= 1'b0;
         IRQ_HDCP14_TMR <= 1'b0;
         IRQ_HDCP22_TMR <= 1'b0;
      end
      else
      begin
         // [RQ11] lines held by flags
         IRQ_HPD <= EV_PENDING[`HTE_EV_CONN] | EV_PENDING[`HTE_EV_DISC];
         // [RQ5] one line for both link directions
         IRQ_LINK <= EV_PENDING[`HTE_EV_LINK] | EV_PENDING[`HTE_EV_UP]
            | EV_PENDING[`HTE_EV_DOWN];
         IRQ_VSYNC <= EV_PENDING[`HTE_EV_VS];
         IRQ_HDCP14 <= EV_PENDING[`HTE_EV_H14];
         IRQ_HDCP14_TMR <= EV_PENDING[`HTE_EV_H14T];
         IRQ_HDCP22_TMR <= EV_PENDING[`HTE_EV_H22T];
      end

   // ---------------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_B);

   // [RQ1] connect flag set
   conn_set_a: assert property ($rose(in_s2_q[`HTE_IN_HPD]) |=> EV_PENDING[`HTE_EV_CONN]
      ##1 IRQ_HPD) else $error("connect edge not flagged"); // [RQ1]

   // [RQ2] disconnect flag set
   disc_set_a: assert property ($fell(in_s2_q[`HTE_IN_HPD])
      |=> EV_PENDING[`HTE_EV_DISC] ##1 IRQ_HPD)
      else $error("disconnect edge not flagged"); // [RQ2]

   // [RQ5] link change flagged
   link_chg_a: assert property ((link_s != link_p_q) |=> EV_PENDING[`HTE_EV_LINK]
      ##1 IRQ_LINK && LINK_STATUS == $past(link_s, 2)) else $error("link change lost"); // [RQ5]

   // [RQ6] stream up event
   up_set_a: assert property ($rose(link_s) |=> EV_PENDING[`HTE_EV_UP])
      else $error("stream up not flagged"); // [RQ6]

   // [RQ7] stream down event
   down_set_a: assert property ($fell(link_s) |=> EV_PENDING[`HTE_EV_DOWN])
      else $error("stream down not flagged"); // [RQ7]

   // [RQ7] directions kept apart
   dir_excl_a: assert property (ev[`HTE_EV_UP] |-> !ev[`HTE_EV_DOWN] && ev[`HTE_EV_LINK])
      else $error("stream up and down together"); // [RQ7]

   // [RQ8] vsync flag set
   vs_set_a: assert property (!in_p_q[`HTE_IN_VS] && in_s2_q[`HTE_IN_VS]
      |=> EV_PENDING[`HTE_EV_VS] ##1 IRQ_VSYNC) else $error("vsync edge not flagged"); // [RQ8]

   // [RQ9] hdcp 1.4 absent
   h14_off_a: assert property (!HDCP14_EN |-> !EV_PENDING[`HTE_EV_H14]
      && !EV_PENDING[`HTE_EV_H14T] && !IRQ_HDCP14) else $error("hdcp 1.4 interrupt w/o engine"); // [RQ9]

   // [RQ10] hdcp 2.2 absent
   h22_off_a: assert property (!HDCP22_EN |-> !EV_PENDING[`HTE_EV_H22T] && !IRQ_HDCP22_TMR)
      else $error("hdcp 2.2 interrupt without engine"); // [RQ10]

   // [RQ11] flag held until cleared
   pend_hold_a: assert property (EV_PENDING[`HTE_EV_VS] && !EV_CLR[`HTE_EV_VS]
      |=> EV_PENDING[`HTE_EV_VS] [*1] ##1 IRQ_VSYNC) else $error("vsync flag dropped"); // [RQ11]

   // [RQ11] clear drops quiet flag
   pend_clr_a: assert property (EV_CLR[`HTE_EV_CONN] && !ev[`HTE_EV_CONN]
      |=> !EV_PENDING[`HTE_EV_CONN]) else $error("connect flag not cleared"); // [RQ11]

   // [RQ1] level follows pin
   hpd_lvl_a: assert property (HPD_LEVEL == $past(in_s2_q[`HTE_IN_HPD]))
      else $error("hpd level out of step"); // [RQ1]

   // [RQ3] status bit out
   link_out_a: assert property (LINK_STATUS == $past(link_s))
      else $error("link status out of step"); // [RQ3]

   // [RQ11] hpd line from flags
   irq_hpd_a: assert property (IRQ_HPD == $past(EV_PENDING[`HTE_EV_CONN] || EV_PENDING[`HTE_EV_DISC]))
      else $error("hpd line not following flags"); // [RQ11]

   // [RQ5] link line from flags
   irq_link_a: assert property (IRQ_LINK == $past(EV_PENDING[`HTE_EV_LINK]
      || EV_PENDING[`HTE_EV_UP] || EV_PENDING[`HTE_EV_DOWN])) else $error("link line wrong"); // [RQ5]

   // [RQ8] vsync line from flag
   irq_vs_a: assert property (IRQ_VSYNC == $past(EV_PENDING[`HTE_EV_VS]))
      else $error("vsync line not following flag"); // [RQ8]

   // [RQ9] hdcp 1.4 lines
   irq_h14_a: assert property (IRQ_HDCP14 == $past(EV_PENDING[`HTE_EV_H14])
      && IRQ_HDCP14_TMR == $past(EV_PENDING[`HTE_EV_H14T])) else $error("hdcp 1.4 line wrong"); // [RQ9]

   // [RQ10] hdcp 2.2 line
   irq_h22_a: assert property (IRQ_HDCP22_TMR == $past(EV_PENDING[`HTE_EV_H22T]))
      else $error("hdcp 2.2 line wrong"); // [RQ10]

   // [RQ11] set beats clear
   set_wins_a: assert property (ev[`HTE_EV_DISC] && EV_CLR[`HTE_EV_DISC]
      |=> EV_PENDING[`HTE_EV_DISC]) else $error("event lost to clear"); // [RQ11]

   // [RQ11] vsync flag set only by its event
   pend_src_a: assert property ($rose(EV_PENDING[`HTE_EV_VS]) |-> $past(ev[`HTE_EV_VS]))
      else $error("vsync flag set without event"); // [RQ11]

   // [RQ9] hdcp 1.4 engine flag
   h14_set_a: assert property (in_rise[`HTE_IN_H14] |=> EV_PENDING[`HTE_EV_H14])
      else $error("hdcp 1.4 edge not flagged"); // [RQ9]

   // [RQ9] hdcp 1.4 timer flag
   h14t_set_a: assert property (in_rise[`HTE_IN_H14T] |=> EV_PENDING[`HTE_EV_H14T]
      ##1 IRQ_HDCP14_TMR) else $error("hdcp 1.4 timer edge not flagged"); // [RQ9]

   // [RQ10] hdcp 2.2 timer flag
   h22_set_a: assert property (in_rise[`HTE_IN_H22T] |=> EV_PENDING[`HTE_EV_H22T]
      ##1 IRQ_HDCP22_TMR) else $error("hdcp 2.2 timer edge not flagged"); // [RQ10]

   // [RQ6] one direction per change
   link_pair_a: assert property (ev[`HTE_EV_LINK] |-> ev[`HTE_EV_UP] != ev[`HTE_EV_DOWN])
      else $error("link change without direction"); // [RQ6]

   // [RQ9] absent timer line quiet
   h14t_off_a: assert property (!HDCP14_EN |-> !IRQ_HDCP14_TMR)
      else $error("hdcp 1.4 timer line without engine"); // [RQ9]

endmodule

/* File: src/hte_params.svh */
// constants for the transmitter event and interrupt source block
// assumes a 250 MHz system clock and a regenerated link clock of unknown rate
//
// Function
// [RQ1] a rising edge on the hot-plug detect input raises a cable-connected event.
// [RQ2] a falling edge on the hot-plug detect input raises a cable-disconnected event.
// [RQ3] the link status bit is set to 1 once the regenerated link clock is seen stable.
// [RQ4] the link status bit is cleared to 0 as soon as the link clock becomes unstable.
// [RQ5] every change of the link status bit raises a link ready interrupt.
// [RQ6] a rising link status bit is also reported as a stream-up event.
// [RQ7] a falling link status bit is also reported as a separate stream-down event.
// [RQ8] a rising edge of the video vertical sync input raises a vertical sync interrupt.
// [RQ9] the two HDCP 1.4 interrupts exist only when HDCP 1.4 is built in.
// [RQ10] the HDCP 2.2 timer interrupt exists only when HDCP 2.2 is built in.
// [RQ11] each event stays pending, holding its interrupt high, until software clears it.
`ifndef HTE_PARAMS_SVH
`define HTE_PARAMS_SVH

// ----------------------------------------------------------------------------
// event vector positions
// ----------------------------------------------------------------------------
`define HTE_EV_NUM 9
`define HTE_EV_CONN 0
`define HTE_EV_DISC 1
`define HTE_EV_LINK 2
`define HTE_EV_UP 3
`define HTE_EV_DOWN 4
`define HTE_EV_VS 5
`define HTE_EV_H14 6
`define HTE_EV_H14T 7
`define HTE_EV_H22T 8

// ----------------------------------------------------------------------------
// synchronised input positions
// ----------------------------------------------------------------------------
`define HTE_IN_NUM 5
`define HTE_IN_HPD 0
`define HTE_IN_VS 1
`define HTE_IN_H14 2
`define HTE_IN_H14T 3
`define HTE_IN_H22T 4

// ----------------------------------------------------------------------------
// link clock monitor timing
// ----------------------------------------------------------------------------
`define HTE_SYS_PERIOD_NS 4
`define HTE_LINK_DIV_W 3
`define HTE_LOSS_TIME_NS 2000
`define HTE_LOSS_CYC ((`HTE_LOSS_TIME_NS) / (`HTE_SYS_PERIOD_NS))
`define HTE_WD_W 12
`define HTE_QUAL_EDGES 4
`define HTE_QUAL_W 3
`define HTE_PEND_RST 9'h000

`endif

/* File: src/hte_pkg.sv */
// types shared by the event and interrupt source block
// assumes hte_params.svh sets the vector widths
`include "hte_params.svh"

package hte_pkg;

   // link clock qualifier states
   typedef enum logic [1:0] {LNK_DOWN, LNK_QUAL, LNK_UP} hte_link_e;

   // one bit per event source
   typedef logic [`HTE_EV_NUM-1:0] hte_ev_t;

endpackage

/* File: src/hte_link_mon.sv */
// link clock stability monitor
// assumes link_clk may stop or glitch while the phy is reconfigured
`include "hte_params.svh"

module hte_link_mon
   import hte_pkg::*;
(
   // system side
   input wire logic sys_clk,
   input wire logic rst_b,
   // link side
   input wire logic link_clk,
   // status toward system side
   output logic link_up
);

   // ---------------------------------------------------------------------
   // link domain
   // ---------------------------------------------------------------------
   logic [1:0] lrst_q;
   logic [`HTE_LINK_DIV_W-1:0] div_q;
   logic tog_q;

   // reset released in step with the link clock
   always_ff @(posedge link_clk or negedge rst_b)
      if (!rst_b)
         lrst_q <= 2'h0;
      else
         lrst_q <= {lrst_q[0], 1'b1};

   // slow toggle, so the system side samples it safely
   always_ff @(posedge link_clk or negedge rst_b)
      if (!rst_b)
      begin
         div_q <= '0;
         tog_q <= 1'b0;
      end
      else if (lrst_q[1])
      begin
         div_q <= div_q + 1'b1;
         if (&div_q)
            tog_q <= ~tog_q;
      end

   // ---------------------------------------------------------------------
   // system domain
   // ---------------------------------------------------------------------
   logic tog_s1_q, tog_s2_q, tog_s3_q;
   logic edge_seen;
   logic [`HTE_WD_W-1:0] wd_q;
   logic [`HTE_QUAL_W-1:0] qual_q;
   logic timeout;
   hte_link_e state_q;

   // toggle crossing, first stage read only by the second
   always_ff @(posedge sys_clk or negedge rst_b)
      if (!rst_b)
      begin
         tog_s1_q <= 1'b0;
         tog_s2_q <= 1'b0;
         tog_s3_q <= 1'b0;
      end
      else
      begin
         tog_s1_q <= tog_q;
         tog_s2_q <= tog_s1_q;
         tog_s3_q <= tog_s2_q;
      end

   assign edge_seen = tog_s2_q ^ tog_s3_q;
   assign timeout = (wd_q == `HTE_WD_W'(`HTE_LOSS_CYC - 1)) && !edge_seen;

   // watchdog restarts on each toggle seen
   always_ff @(posedge sys_clk or negedge rst_b)
      if (!rst_b)
         wd_q <= '0;
      else if (edge_seen || timeout)
         wd_q <= '0;
      else
         wd_q <= wd_q + 1'b1;

   // needs several toggles in a row; one stray edge is not enough
   always_ff @(posedge sys_clk or negedge rst_b)
      if (!rst_b)
      begin
         state_q <= LNK_DOWN;
         qual_q <= '0;
      end
      else
      begin
         unique case (state_q)
            LNK_DOWN:
               if (edge_seen)
               begin
                  state_q <= LNK_QUAL;
                  qual_q <= `HTE_QUAL_W'(1);
               end
            LNK_QUAL:
               if (timeout)
                  state_q <= LNK_DOWN;
               else if (edge_seen)
               begin
                  qual_q <= qual_q + 1'b1;
                  if (qual_q == `HTE_QUAL_W'(`HTE_QUAL_EDGES - 1))
                     state_q <= LNK_UP;
               end
            LNK_UP:
               if (timeout)
                  state_q <= LNK_DOWN;
         endcase
      end

   // [RQ3] [RQ4] status follows qualifier
   always_ff @(posedge sys_clk or negedge rst_b)
      if (!rst_b)
         link_up <= 1'b0;
      else
         link_up <= (state_q == LNK_UP);

   // [RQ4] loss drops status
   link_loss_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      timeout |-> ##2 !link_up) else $error("link status kept after clock loss"); // [RQ4]

   // [RQ3] status only after qualification
   link_qual_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(link_up) |-> $past(state_q, 2) == LNK_QUAL && $past(edge_seen, 2))
      else $error("link status rose without qualification"); // [RQ3]

endmodule

/* File: bench/hte_cpu_model.sv */
// processor side model: services pending flags by pulsing their clear strobes
// assumes the bench enables service and sets its latency; strobes move at the falling edge
`include "hte_params.svh"

module hte_cpu_model
   import hte_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // service control from the bench
   input wire logic ack_en,
   input wire logic [7:0] lat,
   // device side
   input wire hte_ev_t pend,
   output hte_ev_t clr
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0] wait_q;

   // ------------------------------------------------------------------
   // interrupt service
   // ------------------------------------------------------------------
   // one strobe per service, so a flag that is still visible is not cleared twice
   // software clears flags
   always @(negedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wait_q <= 8'h00;
         clr <= '0;
      end
      else
      begin
         clr <= '0;
         if (ack_en && pend != '0 && clr == '0)
         begin
            if (wait_q >= lat)
            begin
               clr <= pend;  // acknowledge every flag seen
               wait_q <= 8'h00;
            end
            else
               wait_q <= wait_q + 8'h01;
         end
         else
            wait_q <= 8'h00;
      end
   end
endmodule

/* File: bench/tb_top.sv */
// self-checking bench for the event and interrupt source block
// assumes a processor model that clears flags only while the bench lets it serve
`include "hte_params.svh"

module tb_top
   import hte_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct {logic [4:0] pins; hte_ev_t pend; logic [5:0] irq;} hte_row_s;

   logic sys_clk = 1'b0;
   logic link_clk = 1'b0;
   logic link_run = 1'b1;
   logic rst_b = 1'b0;
   logic ack_en = 1'b0;
   logic [7:0] lat = 8'h00;
   logic [4:0] pins = 5'h00;  // {hdcp22 tmr, hdcp14 tmr, hdcp14, vsync, hpd}
   hte_ev_t ev_clr;
   hte_ev_t ev_pend;
   logic hpd_lvl;
   logic link_st;
   logic [5:0] irq;
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;
   int n;
   hte_row_s rows [8] = '{
      '{5'h01, 9'h001, 6'h01}, '{5'h00, 9'h002, 6'h01}, '{5'h02, 9'h020, 6'h04},
      '{5'h00, 9'h000, 6'h00}, '{5'h04, 9'h040, 6'h08}, '{5'h0C, 9'h080, 6'h10},
      '{5'h1C, 9'h100, 6'h20}, '{5'h00, 9'h000, 6'h00}};

   // ------------------------------------------------------------------
   // clocks and timeout
   // ------------------------------------------------------------------
   always #2 sys_clk = ~sys_clk;

   // link clock stands low while stopped; offset keeps it out of phase
   initial
   begin
      #7.3;
      forever #15 link_clk = link_run ? ~link_clk : 1'b0;
   end

   // ceiling well above the link qualify and loss times
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         finish_test();
      end
   end

   // ------------------------------------------------------------------
   // design and partner
   // ------------------------------------------------------------------
   hte_irq_top hte_irq_top_i (.SYS_CLK(sys_clk), .RST_B(rst_b), .LINK_CLK(link_clk),
      .HPD_IN(pins[0]), .VSYNC_IN(pins[1]), .HDCP14_IRQ_IN(pins[2]),
      .HDCP14_TMR_IN(pins[3]), .HDCP22_TMR_IN(pins[4]), .EV_CLR(ev_clr),
      .EV_PENDING(ev_pend), .HPD_LEVEL(hpd_lvl), .LINK_STATUS(link_st),
      .IRQ_HPD(irq[0]), .IRQ_LINK(irq[1]), .IRQ_VSYNC(irq[2]), .IRQ_HDCP14(irq[3]),
      .IRQ_HDCP14_TMR(irq[4]), .IRQ_HDCP22_TMR(irq[5]));

   hte_cpu_model hte_cpu_model_i (.clk(sys_clk), .rst_b(rst_b), .ack_en(ack_en),
      .lat(lat), .pend(ev_pend), .clr(ev_clr));

   // ------------------------------------------------------------------
   // compare, service and closing tasks
   // ------------------------------------------------------------------
   task automatic cmp_ev(input hte_ev_t act, input hte_ev_t exp);
      checked++;
      if (act !== exp)
      begin
         n_mismatch++;
         $display("Error t=%0t pending act=%h exp=%h", $time, act, exp);
      end
   endtask

   task automatic cmp_irq(input logic [5:0] act, input logic [5:0] exp);
      checked++;
      if (act !== exp)
      begin
         n_mismatch++;
         $display("Error t=%0t irq act=%h exp=%h", $time, act, exp);
      end
   endtask

   task automatic cmp_lvl(input logic act, input logic exp);
      checked++;
      if (act !== exp)
      begin
         n_mismatch++;
         $display("Error t=%0t level act=%h exp=%h", $time, act, exp);
      end
   endtask

   // let the model serve, then flags and lines must be back to zero
   task automatic serve();
      @(negedge sys_clk) ack_en = 1'b1;
      for (n = 0; n < 60 && ev_pend !== '0; n++) @(negedge sys_clk);
      repeat (3) @(negedge sys_clk);
      ack_en = 1'b0;
      cmp_ev(ev_pend, 9'h000);
      cmp_irq(irq, 6'h00);
   endtask

   task automatic finish_test();
      if (n_mismatch == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial
   begin
      // link clock runs through reset but is stopped one cycle before release
      repeat (9) @(negedge sys_clk);
      cmp_ev(ev_pend, 9'h000);
      cmp_irq(irq, 6'h00);
      link_run = 1'b0;
      @(negedge sys_clk) rst_b = 1'b1;
      // pin edges from the table, each flag then served
      foreach (rows[i])
      begin
         @(negedge sys_clk) pins = rows[i].pins;
         repeat (8) @(negedge sys_clk);
         cmp_ev(ev_pend, rows[i].pend);
         cmp_irq(irq, rows[i].irq);
         cmp_lvl(hpd_lvl, rows[i].pins[0]);
         serve();
      end
      // flag stands while unserved and through a slow service
      pins[0] = 1'b1;
      repeat (40) @(negedge sys_clk);
      cmp_ev(ev_pend, 9'h001);
      lat = 8'd20;
      ack_en = 1'b1;
      repeat (12) @(negedge sys_clk);
      cmp_irq(irq, 6'h01);
      serve();
      lat = 8'h00;
      // link clock starts: status rises, change and stream-up flags
      link_run = 1'b1;
      for (n = 0; n < 3000 && link_st !== 1'b1; n++) @(negedge sys_clk);
      cmp_lvl(link_st, 1'b1);
      repeat (4) @(negedge sys_clk);
      cmp_ev(ev_pend, 9'h00C);
      cmp_irq(irq, 6'h02);
      serve();
      // link clock stops: status falls within the loss window
      link_run = 1'b0;
      for (n = 0; n < 700 && link_st !== 1'b0; n++) @(negedge sys_clk);
      cmp_lvl(link_st, 1'b0);
      cmp_lvl(n >= 370 && n <= 510, 1'b1);
      repeat (4) @(negedge sys_clk);
      cmp_ev(ev_pend, 9'h014);
      serve();
      // second reset with the cable present: outputs clear, connect follows release
      link_run = 1'b1;
      rst_b = 1'b0;
      repeat (10) @(negedge sys_clk);
      cmp_ev(ev_pend, 9'h000);
      cmp_lvl(hpd_lvl | link_st, 1'b0);
      link_run = 1'b0;
      rst_b = 1'b1;
      repeat (8) @(negedge sys_clk);
      cmp_ev(ev_pend, 9'h001);
      finish_test();
   end
endmodule
